// File: design/lvl_vec_8030_pkg.sv
package lvl_vec_8030_pkg;

  // ----------------------------------------
  // bus and register indexes (byte address is four times the index)
  // ----------------------------------------
  localparam int          WB_ADR_W      = 18;
  localparam logic [15:0] IDX_LVL_LOW   = 16'h7f04;
  localparam logic [15:0] IDX_LVL_HIGH  = 16'h7f05;
  localparam logic [15:0] IDX_EXC_LOW   = 16'h7f08;
  localparam logic [15:0] IDX_EXC_HIGH  = 16'h7f09;
  localparam logic [15:0] IDX_IRQ_STAT  = 16'h7f10;
  localparam logic [15:0] IDX_IRQ_MASK  = 16'h7f11;
  localparam logic [15:0] IDX_REQ_STAT  = 16'h7f12;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int          EH_SER_FLG    = 5;
  localparam int          EH_SER_EN     = 4;
  localparam int          EH_SER_MASK   = 2;
  localparam int          PSW_IE        = 7;
  localparam int          PSW_THR_LO    = 8;
  localparam int          PSW_THR_HI    = 10;
  localparam int          PSW_WS        = 11;
  localparam int          EXC_CLKSTOP   = 3;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [1:0]  LVL_OFF       = 2'h0;

  // ----------------------------------------
  // status bits of the event register
  // ----------------------------------------
  localparam int          ST_W          = 3;
  localparam int          ST_EXC_REQ    = 0;
  localparam int          ST_REFUSED    = 1;
  localparam int          ST_CLKSTOP    = 2;

  // ----------------------------------------
  // vectors
  // ----------------------------------------
  localparam logic [15:0] VEC_BASE      = 16'h8020;
  localparam logic [15:0] VEC_EXC       = 16'h8080;

endpackage

// File: design/lvl_vec_8030_top.sv
module lvl_vec_8030_top #(
  parameter int NUM_SRC = 8
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [lvl_vec_8030_pkg::WB_ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic [31:0]                    wb_dat_i,
  output logic      [31:0]                    wb_dat_o,
  output logic                                wb_ack_o,
  input  wire logic [15:0]                    psw_i,
  input  wire logic [NUM_SRC-1:0]             irq_src_i,
  input  wire logic                           clk_stop_i,
  input  wire logic                           addr_err_i,
  input  wire logic                           odd_acc_i,
  input  wire logic                           undef_op_i,
  input  wire logic                           serial0_req_i,
  output logic                                lrc_osc_en_o,
  output logic                                req_o,
  output logic                                req_exc_o,
  output logic      [15:0]                    req_vec_o,
  output logic      [1:0]                     req_lvl_o,
  output logic                                irq_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]             lvl_low;
  logic [7:0]             lvl_high;
  logic [3:0]             exc_en;
  logic [3:0]             exc_flg;
  logic                   ser_flg;
  logic                   ser_en;
  logic                   ser_mask;
  logic [lvl_vec_8030_pkg::ST_W-1:0] stat;
  logic [lvl_vec_8030_pkg::ST_W-1:0] mask;
  logic                   cs_s1;
  logic                   cs_s2;
  logic                   cs_s3;
  logic                   cs_lvl;
  logic                   exc_prev;

  logic                   acc;
  logic                   wr;
  logic                   rd;
  logic [15:0]            idx;
  logic                   ws;
  logic                   ie;
  logic [2:0]             thr;
  logic                   wr_exl;
  logic                   wr_exh;
  logic                   cs_rise;
  logic [3:0]             exc_ev;
  logic                   ser_pend;
  logic                   exc_any;
  logic [1:0]             best_lvl;
  logic [2:0]             best_idx;
  logic                   best_hit;
  logic                   per_accept;
  logic [7:0]             next_rdat;
  logic [lvl_vec_8030_pkg::ST_W-1:0] stat_ev;

  // level field of source i out of both bank-two registers
  function automatic logic [1:0] field_lvl(input logic [15:0] lv, input int i);
    field_lvl = lv[2*i +: 2];
  endfunction

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign acc    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr     = acc & wb_we_i & wb_sel_i[0];
  assign rd     = acc & ~wb_we_i;
  assign idx    = wb_adr_i[lvl_vec_8030_pkg::WB_ADR_W-1:2];
  assign ws     = psw_i[lvl_vec_8030_pkg::PSW_WS];
  assign ie     = psw_i[lvl_vec_8030_pkg::PSW_IE];
  assign thr    = psw_i[lvl_vec_8030_pkg::PSW_THR_HI:lvl_vec_8030_pkg::PSW_THR_LO];
  assign wr_exl = wr & ws & (idx == lvl_vec_8030_pkg::IDX_EXC_LOW);
  assign wr_exh = wr & ws & (idx == lvl_vec_8030_pkg::IDX_EXC_HIGH);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= {24'h00_0000, next_rdat};
    end
  end

  // ----------------------------------------
  // read mux; unmapped words read as zero
  // ----------------------------------------
  always_comb begin
    next_rdat = lvl_vec_8030_pkg::RST_BYTE;
    unique case (idx)
      lvl_vec_8030_pkg::IDX_LVL_LOW:  next_rdat = lvl_low;
      lvl_vec_8030_pkg::IDX_LVL_HIGH: next_rdat = lvl_high;
      lvl_vec_8030_pkg::IDX_EXC_LOW:  next_rdat = {exc_flg[3], exc_en[3], exc_flg[2], exc_en[2],
                                           exc_flg[1], exc_en[1], exc_flg[0], exc_en[0]};
      lvl_vec_8030_pkg::IDX_EXC_HIGH: next_rdat = {2'h0, ser_flg, ser_en, 1'b0, ser_mask, 2'h0};
      lvl_vec_8030_pkg::IDX_IRQ_STAT: next_rdat = {5'h00, stat};
      lvl_vec_8030_pkg::IDX_IRQ_MASK: next_rdat = {5'h00, mask};
      lvl_vec_8030_pkg::IDX_REQ_STAT: next_rdat = {req_o, req_exc_o, req_lvl_o, 1'b0, req_vec_o[4:2]};
      default:                next_rdat = lvl_vec_8030_pkg::RST_BYTE;
    endcase
  end

  // ----------------------------------------
  // level registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_low  <= lvl_vec_8030_pkg::RST_BYTE;
      lvl_high <= lvl_vec_8030_pkg::RST_BYTE;
    end else if (wr && idx == lvl_vec_8030_pkg::IDX_LVL_LOW) begin
      lvl_low  <= wb_dat_i[7:0];
    end else if (wr && idx == lvl_vec_8030_pkg::IDX_LVL_HIGH) begin
      lvl_high <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------
  // clock-stop detector input, three stages
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_s1  <= 1'b0;
      cs_s2  <= 1'b0;
      cs_s3  <= 1'b0;
      cs_lvl <= 1'b0;
    end else begin
      cs_s1 <= clk_stop_i;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      if (cs_s2 == cs_s3) begin
        cs_lvl <= cs_s3;
      end
    end
  end

  assign cs_rise = (cs_s2 == cs_s3) & cs_s3 & ~cs_lvl;
  // detector only runs while its enable is set, so gate the event too
  assign exc_ev  = {cs_rise & exc_en[lvl_vec_8030_pkg::EXC_CLKSTOP],
                    addr_err_i,
                    odd_acc_i,
                    undef_op_i};

  // ----------------------------------------
  // exception low register: enable/flag pairs
  // ----------------------------------------
  for (genvar k = 0; k < 4; k++) begin : g_exc
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        exc_en[k] <= 1'b0;
      end else if (wr_exl) begin
        exc_en[k] <= wb_dat_i[2*k];
      end
    end

    // set wins over a clearing write; writing one keeps the flag
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        exc_flg[k] <= 1'b0;
      end else begin
        exc_flg[k] <= exc_ev[k] | (exc_flg[k] & ~(wr_exl & ~wb_dat_i[2*k+1]));
      end
    end
  end

  // slow rc oscillator and detector follow the clock-stop enable
  assign lrc_osc_en_o = exc_en[lvl_vec_8030_pkg::EXC_CLKSTOP];

  // ----------------------------------------
  // exception high register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_en   <= 1'b0;
      ser_mask <= 1'b0;
    end else if (wr_exh) begin
      // reserved bits are not stored and read zero
      ser_en   <= wb_dat_i[lvl_vec_8030_pkg::EH_SER_EN];
      ser_mask <= wb_dat_i[lvl_vec_8030_pkg::EH_SER_MASK];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_flg <= 1'b0;
    end else begin
      ser_flg <= serial0_req_i;
    end
  end

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  assign ser_pend = ser_en & ser_flg & (~ser_mask | ie);
  assign exc_any  = (|(exc_en & exc_flg)) | ser_pend;

  // walk downwards so that ties settle on the lowest vector
  always_comb begin
    best_lvl = lvl_vec_8030_pkg::LVL_OFF;
    best_idx = 3'h0;
    best_hit = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (irq_src_i[i] && field_lvl({lvl_high, lvl_low}, i) != lvl_vec_8030_pkg::LVL_OFF
          && field_lvl({lvl_high, lvl_low}, i) >= best_lvl) begin
        best_lvl = field_lvl({lvl_high, lvl_low}, i);
        best_idx = 3'(i);
        best_hit = 1'b1;
      end
    end
  end

  assign per_accept = best_hit & ie & ({1'b0, best_lvl} > thr);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_o     <= 1'b0;
      req_exc_o <= 1'b0;
      req_vec_o <= 16'h0000;
      req_lvl_o <= lvl_vec_8030_pkg::LVL_OFF;
    end else begin
      req_o     <= exc_any | per_accept;
      req_exc_o <= exc_any;
      if (exc_any) begin
        req_vec_o <= lvl_vec_8030_pkg::VEC_EXC;
        req_lvl_o <= lvl_vec_8030_pkg::LVL_OFF;
      end else begin
        req_vec_o <= lvl_vec_8030_pkg::VEC_BASE + {11'h000, best_idx, 2'h0};
        req_lvl_o <= per_accept ? best_lvl : lvl_vec_8030_pkg::LVL_OFF;
      end
    end
  end

  // ----------------------------------------
  // event status, mask and interrupt line
  // ----------------------------------------
  assign stat_ev = {cs_rise & exc_en[lvl_vec_8030_pkg::EXC_CLKSTOP],
                    wr & ~ws & (idx == lvl_vec_8030_pkg::IDX_EXC_LOW || idx == lvl_vec_8030_pkg::IDX_EXC_HIGH),
                    exc_any & ~exc_prev};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exc_prev <= 1'b0;
    end else begin
      exc_prev <= exc_any;
    end
  end

  // read clears, but an event in the same cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat <= '0;
    end else begin
      stat <= stat_ev | (stat & ~{lvl_vec_8030_pkg::ST_W{rd && idx == lvl_vec_8030_pkg::IDX_IRQ_STAT}});
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= '0;
    end else if (wr && idx == lvl_vec_8030_pkg::IDX_IRQ_MASK) begin
      mask <= wb_dat_i[lvl_vec_8030_pkg::ST_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat & mask);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cs_quiet;
    (!clk_stop_i)[*3];
  endsequence

  sequence s_cs_stopped;
    (clk_stop_i && exc_en[lvl_vec_8030_pkg::EXC_CLKSTOP])[*4];
  endsequence

  a_cs_flag_set: assert property (s_cs_quiet ##1 s_cs_stopped |=> exc_flg[3])
    else $error("clock stop did not set its flag");

  a_ws_lock: assert property (
    wr && !ws && idx == lvl_vec_8030_pkg::IDX_EXC_LOW |=> exc_en == $past(exc_en))
    else $error("exception enables changed while locked");

  a_ws_lock_high: assert property (
    wr && !ws && idx == lvl_vec_8030_pkg::IDX_EXC_HIGH |=> ser_en == $past(ser_en) && ser_mask == $past(ser_mask))
    else $error("exception high bits changed while locked");

  a_flag_hold: assert property (
    exc_flg[2] && !(wr && idx == lvl_vec_8030_pkg::IDX_EXC_LOW) |=> exc_flg[2])
    else $error("address error flag cleared without a write");

  a_flag_clear: assert property (
    wr_exl && !wb_dat_i[5] && !addr_err_i |=> !exc_flg[2])
    else $error("address error flag not cleared by a zero write");

  a_odd_set: assert property (odd_acc_i |=> exc_flg[1])
    else $error("odd access did not set its flag");

  a_exc_wins: assert property (
    exc_any |=> req_o && req_exc_o && req_vec_o == lvl_vec_8030_pkg::VEC_EXC)
    else $error("exception request not on the shared vector");

  a_thr_above: assert property (
    req_o && !req_exc_o |-> {1'b0, req_lvl_o} > $past(thr) && $past(ie))
    else $error("peripheral accepted at or below threshold");

  a_level_off: assert property (
    req_o && !req_exc_o |-> req_lvl_o != lvl_vec_8030_pkg::LVL_OFF)
    else $error("disabled level was granted");

  a_ser_masked: assert property (
    ser_mask && !ie && !(|(exc_en & exc_flg)) |=> !req_exc_o)
    else $error("masked serial request passed without global enable");

  a_irq_line: assert property (|(stat & mask) |=> irq_o)
    else $error("interrupt line low with unmasked status");

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

endmodule

// File: verif/lvl_vec_8030_core_model.sv
// ----------------------------------------
// core side: status word and taken vector
// ----------------------------------------
module lvl_vec_8030_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ie_i,
  input  wire logic [2:0]  thr_i,
  input  wire logic        ws_i,
  input  wire logic        req_i,
  input  wire logic [15:0] req_vec_i,
  output logic      [15:0] psw_o,
  output logic      [15:0] taken_vec_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // registered, so the block never sees a mid-cycle change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psw_o <= 16'h0000;
    end else begin
      psw_o <= {4'h0, ws_i, thr_i, ie_i, 7'h00};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      taken_vec_o <= 16'h0000;
    end else if (req_i) begin
      taken_vec_o <= req_vec_i;
    end
  end
endmodule

// File: verif/irq_level_and_exception_ctrl_tb.sv
module irq_level_and_exception_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                          clk_i = 1'b0;
  logic                          rst_i = 1'b1;
  logic                          cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [lvl_vec_8030_pkg::WB_ADR_W-1:0] adr = '0;
  logic [31:0]                   wdat = 32'h0, rdat;
  logic                          ack, ie = 1'b0, ws = 1'b0, cstop = 1'b0, aerr = 1'b0;
  logic                          oacc = 1'b0, uop = 1'b0, ser = 1'b0;
  logic [2:0]                    thr = 3'h0;
  logic [7:0]                    src = 8'h00, q;
  logic [15:0]                   processor_status_word, vec, core_vec, lv;
  logic                          osc, req, rexc, irq;
  logic [1:0]                    lvl;
  int                            failures = 0;
  int                            checks = 0;

  always #5 clk_i = ~clk_i;

  lvl_vec_8030_core_model core (.clk_i(clk_i), .rst_i(rst_i), .ie_i(ie), .thr_i(thr), .ws_i(ws),
    .req_i(req), .req_vec_i(vec), .psw_o(processor_status_word), .taken_vec_o(core_vec));

  lvl_vec_8030_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .psw_i(processor_status_word), .irq_src_i(src), .clk_stop_i(cstop), .addr_err_i(aerr), .odd_acc_i(oacc),
    .undef_op_i(uop), .serial0_req_i(ser), .lrc_osc_en_o(osc), .req_o(req), .req_exc_o(rexc),
    .req_vec_o(vec), .req_lvl_o(lvl), .irq_o(irq));

  // ----------------------------------------
  // access, check and helper tasks
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; waits for ack with no fixed count
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk({8'h00, q}, {8'h00, exp});
  endtask

  task automatic wn(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // no vector check when idle: its value is then unspecified
  task automatic rq(input logic r, input logic e, input logic [15:0] v, input logic [1:0] l);
    wn(3);
    chk({12'h0, req, rexc, lvl}, {12'h0, r, e, l});
    if (r) chk(vec, v);
  endtask

  // one-cycle event pulse on {aerr, oacc, uop}
  task automatic pulse(input logic [2:0] e);
    {aerr, oacc, uop} <= e;
    @(posedge clk_i);
    {aerr, oacc, uop} <= 3'h0;
    @(posedge clk_i);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(lvl_vec_8030_pkg::IDX_LVL_LOW, 8'h00);
    rdc(lvl_vec_8030_pkg::IDX_LVL_HIGH, 8'h00);
    rdc(lvl_vec_8030_pkg::IDX_EXC_LOW, 8'h00);
    bus(1'b1, 16'h7f0a, 8'hff);
    rdc(16'h7f0a, 8'h00);
    bus(1'b1, lvl_vec_8030_pkg::IDX_IRQ_MASK, 8'h02);
    bus(1'b1, lvl_vec_8030_pkg::IDX_EXC_LOW, 8'hff);
    rdc(lvl_vec_8030_pkg::IDX_EXC_LOW, 8'h00);
    wn(2); chk({15'h0, irq}, 16'h0001);
    rdc(lvl_vec_8030_pkg::IDX_IRQ_STAT, 8'h02);
    wn(2); chk({15'h0, irq}, 16'h0000);
    ie <= 1'b1; src <= 8'hff;
    for (int i = 0; i < 8; i++) begin
      lv = 16'h0003 << (2 * i);
      bus(1'b1, lvl_vec_8030_pkg::IDX_LVL_LOW, lv[7:0]);
      bus(1'b1, lvl_vec_8030_pkg::IDX_LVL_HIGH, lv[15:8]);
      rq(1'b1, 1'b0, 16'h8020 + 16'(4 * i), 2'h3);
    end
    rdc(lvl_vec_8030_pkg::IDX_LVL_HIGH, 8'hc0);
    bus(1'b1, lvl_vec_8030_pkg::IDX_LVL_HIGH, 8'h00);
    bus(1'b1, lvl_vec_8030_pkg::IDX_LVL_LOW, 8'h6c);
    src <= 8'hff; rq(1'b1, 1'b0, 16'h8024, 2'h3);
    src <= 8'h0d; rq(1'b1, 1'b0, 16'h8028, 2'h2);
    src <= 8'h09; rq(1'b1, 1'b0, 16'h802c, 2'h1);
    src <= 8'h01; rq(1'b0, 1'b0, 16'h0000, 2'h0);
    bus(1'b1, lvl_vec_8030_pkg::IDX_LVL_LOW, 8'haa);
    bus(1'b1, lvl_vec_8030_pkg::IDX_LVL_HIGH, 8'haa);
    src <= 8'hf0; rq(1'b1, 1'b0, 16'h8030, 2'h2);
    rdc(lvl_vec_8030_pkg::IDX_REQ_STAT, 8'ha4);
    thr <= 3'h2; rq(1'b0, 1'b0, 16'h0000, 2'h0);
    thr <= 3'h1; rq(1'b1, 1'b0, 16'h8030, 2'h2);
    ws <= 1'b1; wn(2);
    bus(1'b1, lvl_vec_8030_pkg::IDX_EXC_LOW, 8'h55);
    wn(2); chk({15'h0, osc}, 16'h0001);
    pulse(3'h4);
    rq(1'b1, 1'b1, lvl_vec_8030_pkg::VEC_EXC, 2'h0);
    rdc(lvl_vec_8030_pkg::IDX_EXC_LOW, 8'h75);
    bus(1'b1, lvl_vec_8030_pkg::IDX_EXC_LOW, 8'h55);
    rq(1'b1, 1'b0, 16'h8030, 2'h2);
    pulse(3'h2);
    pulse(3'h1);
    rdc(lvl_vec_8030_pkg::IDX_EXC_LOW, 8'h5f);
    bus(1'b1, lvl_vec_8030_pkg::IDX_EXC_LOW, 8'h5a);
    rq(1'b1, 1'b0, 16'h8030, 2'h2);
    bus(1'b1, lvl_vec_8030_pkg::IDX_IRQ_MASK, 8'h04);
    cstop <= 1'b1; wn(8); cstop <= 1'b0;
    rdc(lvl_vec_8030_pkg::IDX_EXC_LOW, 8'hda);
    chk({15'h0, irq}, 16'h0001);
    rq(1'b1, 1'b1, lvl_vec_8030_pkg::VEC_EXC, 2'h0);
    rdc(lvl_vec_8030_pkg::IDX_IRQ_STAT, 8'h05);
    wn(2); chk({15'h0, irq}, 16'h0000);
    bus(1'b1, lvl_vec_8030_pkg::IDX_EXC_LOW, 8'h00);
    wn(2); chk({15'h0, osc}, 16'h0000);
    bus(1'b1, lvl_vec_8030_pkg::IDX_EXC_HIGH, 8'h14);
    src <= 8'h00; ser <= 1'b1; ie <= 1'b0;
    rq(1'b0, 1'b0, 16'h0000, 2'h0);
    rdc(lvl_vec_8030_pkg::IDX_EXC_HIGH, 8'h34);
    ie <= 1'b1; rq(1'b1, 1'b1, lvl_vec_8030_pkg::VEC_EXC, 2'h0);
    bus(1'b1, lvl_vec_8030_pkg::IDX_EXC_HIGH, 8'h10);
    ie <= 1'b0; rq(1'b1, 1'b1, lvl_vec_8030_pkg::VEC_EXC, 2'h0);
    chk(core_vec, lvl_vec_8030_pkg::VEC_EXC);
    bus(1'b1, lvl_vec_8030_pkg::IDX_EXC_HIGH, 8'h00);
    rdc(lvl_vec_8030_pkg::IDX_EXC_HIGH, 8'h20);
    ser <= 1'b0; wn(3);
    rdc(lvl_vec_8030_pkg::IDX_EXC_HIGH, 8'h00);
    ws <= 1'b0; wn(2);
    bus(1'b1, lvl_vec_8030_pkg::IDX_EXC_HIGH, 8'h14);
    rdc(lvl_vec_8030_pkg::IDX_EXC_HIGH, 8'h00);
    rdc(lvl_vec_8030_pkg::IDX_IRQ_STAT, 8'h03);
    test_done;
  end

  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    test_done;
  end
endmodule
